// *** rtl/ats_cfg.svh ***
`ifndef ATS_CFG_SVH
`define ATS_CFG_SVH

// register byte offsets
`define ATS_OFF_CMD      8'h00
`define ATS_OFF_CFG      8'h04
`define ATS_OFF_PATTERN  8'h08
`define ATS_OFF_MASK     8'h0c
`define ATS_OFF_COUNT    8'h10
`define ATS_OFF_STORE    8'h14
`define ATS_OFF_STATUS   8'h18
`define ATS_OFF_IRQ_STAT 8'h1c
`define ATS_OFF_IRQ_MASK 8'h20
`define ATS_OFF_SEQ      8'h24

// command register bits (write one to act)
`define ATS_CMD_START    0
`define ATS_CMD_HALT     1
`define ATS_CMD_SETUP    2
`define ATS_CMD_INIT     3

// configuration register fields
`define ATS_CFG_COMPLEX  0
`define ATS_CFG_EXPR_LO  1
`define ATS_CFG_EXPR_HI  2
`define ATS_CFG_OUT_A    3
`define ATS_CFG_OUT_B    4
`define ATS_CFG_ARM_LO   5
`define ATS_CFG_ARM_HI   6

// sequencer register branch qualifier fields
`define ATS_SEQ_SEC_LO   4
`define ATS_SEQ_SEC_HI   5
`define ATS_SEQ_RST_LO   7
`define ATS_SEQ_RST_HI   8

// interrupt status bits
`define ATS_IRQ_TRIG     0
`define ATS_IRQ_HALT     1

// reset and initialization values
`define ATS_COUNT_RESET  16'h0001
`define ATS_COUNT_MIN    16'h0001
`define ATS_PATTERN_RST  32'h0000_0000
`define ATS_MASK_RST     32'h0000_0000
`define ATS_STORE_RST    32'h0000_0000

`endif

// *** rtl/ats_pkg.sv ***
package ats_pkg;

  // qualifier expression sources
  typedef enum logic [1:0] {ATS_EXPR_ANY, ATS_EXPR_NEVER, ATS_EXPR_PAT, ATS_EXPR_ARM} ats_expr_type;

  // arm sources; the spare code behaves as always
  typedef enum logic [1:0] {ATS_ARM_ALWAYS, ATS_ARM_LINE_A, ATS_ARM_LINE_B, ATS_ARM_SPARE} ats_arm_type;

  typedef enum logic [1:0] {ATS_IDLE, ATS_RUN, ATS_DONE} ats_run_type;

  typedef struct packed {
    logic [7:0] addr;
    logic       write;
    logic       valid;
  } ats_ahb_req_type;

  typedef struct packed {
    ats_expr_type pri_sel;
    ats_expr_type sec_sel;
    logic [15:0]  count;
    logic         pri_dest;
  } ats_term_type;

endpackage

// *** rtl/ats_occ_counter.sv ***
`timescale 1ns/1ps
module ats_occ_counter
(
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  input  wire logic        reload_in,
  input  wire logic        hit_in,
  input  wire logic [15:0] limit_in,
  output logic             done_out,
  output logic [15:0]      count_out
);
  logic [15:0] count_reg;
  logic [15:0] count_next;
  logic [15:0] count_inc;

  assign count_inc = count_reg + 16'h0001;
  assign count_out = count_reg;
  // done on the qualifying occurrence that reaches the programmed count
  assign done_out  = hit_in && (count_inc >= limit_in);

  always_comb
  begin
    count_next = count_reg;
    if (reload_in || done_out)
    begin
      count_next = 16'h0000;
    end
    else if (hit_in)
    begin
      count_next = count_inc;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      count_reg <= 16'h0000;
    end
    else
    begin
      count_reg <= count_next;
    end
  end
endmodule

// *** rtl/ats_trigger_setup.sv ***
// Operation
// RULE1: trigger once the expression matched the occurrence count, 1 to 65535, default 1.
// RULE2: easy setup: one term, trigger on leaving term 1, restart never, term 1 primary.
// RULE3: complex setup: trigger entering term 2, term 2 secondary never, term 1 branches.
// RULE4: setup leaves the storage qualifier untouched.
// RULE5: arm expression holds off triggering until the selected arm signal arrives.
// RULE6: on trigger drive line a, line b, both or neither; neither after init.
// RULE7: a line used as arm input is never driven, and no error is raised.
// RULE8: primary and secondary in the same state: primary branch wins.
// RULE9: secondary branch taken before count reached clears the occurrence counter.
// RULE10: halting the trace stops driving both cross-trigger lines.
// RULE11: one 16-bit occurrence counter per term, reloaded on entry or restart.
`timescale 1ns/1ps
`include "ats_cfg.svh"
module ats_trigger_setup
(
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  input  wire logic        hsel_in,
  input  wire logic [31:0] haddr_in,
  input  wire logic [1:0]  htrans_in,
  input  wire logic        hwrite_in,
  input  wire logic [2:0]  hsize_in,
  input  wire logic [31:0] hwdata_in,
  input  wire logic        hready_in,
  output logic             hreadyout_out,
  output logic             hresp_out,
  output logic [31:0]      hrdata_out,
  input  wire logic [31:0] bus_state_in,
  input  wire logic        bus_state_valid_in,
  input  wire logic        cross_trigger_line_a_in,
  input  wire logic        cross_trigger_line_b_in,
  output logic             cross_trigger_line_a_out,
  output logic             cross_trigger_line_b_out,
  output logic             trigger_found_out,
  output logic             irq_out
);
  localparam int TERMS = 2;

  ////////////////////////////////////////////////////////////////////////////
  // register state
  ats_pkg::ats_ahb_req_type req_reg, req_next;
  logic                     complex_reg, complex_next;
  ats_pkg::ats_expr_type    expr_reg, expr_next;
  logic [1:0]               out_sel_reg, out_sel_next;
  ats_pkg::ats_arm_type     arm_src_reg, arm_src_next;
  logic [31:0]              pattern_reg, pattern_next;
  logic [31:0]              mask_reg, mask_next;
  logic [15:0]              count_reg, count_next;
  logic [31:0]              store_reg, store_next;
  logic [1:0]               irq_stat_reg, irq_stat_next;
  logic [1:0]               irq_mask_reg, irq_mask_next;
  logic [31:0]              hrdata_reg, hrdata_next;
  ats_pkg::ats_term_type    term_cfg_reg [TERMS];
  ats_pkg::ats_term_type    term_cfg_next [TERMS];
  ats_pkg::ats_expr_type    restart_reg, restart_next;
  logic                     trig_enter_reg, trig_enter_next;

  ////////////////////////////////////////////////////////////////////////////
  // sequencer state
  ats_pkg::ats_run_type     run_reg, run_next;
  logic                     term_reg, term_next;
  logic                     armed_reg, armed_next;
  logic                     trig_reg, trig_next;
  logic [TERMS-1:0]         reload;
  logic [TERMS-1:0]         pri_hit;
  logic [TERMS-1:0]         done;
  logic [15:0]              occ_count [TERMS];

  logic                     addr_take, wr_cmd, rd_stat, pat_match, arm_seen;
  logic                     cmd_start, cmd_halt, cmd_setup, cmd_init;
  logic                     active, sec_hit, trig_event, halt_event;

  function automatic logic qual(input ats_pkg::ats_expr_type sel, input logic pat, input logic armed);
    unique case (sel)
      ats_pkg::ATS_EXPR_ANY:   qual = 1'b1;
      ats_pkg::ATS_EXPR_NEVER: qual = 1'b0;
      ats_pkg::ATS_EXPR_PAT:   qual = pat;
      ats_pkg::ATS_EXPR_ARM:   qual = armed; // [RULE5]
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // bus decode
  assign addr_take     = hsel_in && hready_in && htrans_in[1];
  assign wr_cmd        = req_reg.valid && req_reg.write && (req_reg.addr == `ATS_OFF_CMD);
  assign cmd_start     = wr_cmd && hwdata_in[`ATS_CMD_START];
  assign cmd_halt      = wr_cmd && hwdata_in[`ATS_CMD_HALT];
  assign cmd_setup     = wr_cmd && hwdata_in[`ATS_CMD_SETUP];
  assign cmd_init      = wr_cmd && hwdata_in[`ATS_CMD_INIT];
  assign rd_stat       = addr_take && !hwrite_in && (haddr_in[7:0] == `ATS_OFF_IRQ_STAT);
  assign hreadyout_out = 1'b1;
  assign hresp_out     = 1'b0;
  assign hrdata_out    = hrdata_reg;
  assign irq_out       = |(irq_stat_reg & irq_mask_reg);

  always_comb
  begin
    req_next       = '{addr: haddr_in[7:0], write: hwrite_in, valid: addr_take};
    complex_next   = complex_reg;
    expr_next      = expr_reg;
    out_sel_next   = out_sel_reg;
    arm_src_next   = arm_src_reg;
    pattern_next   = pattern_reg;
    mask_next      = mask_reg;
    count_next     = count_reg;
    store_next     = store_reg;
    irq_mask_next  = irq_mask_reg;
    term_cfg_next  = term_cfg_reg;
    restart_next   = restart_reg;
    trig_enter_next = trig_enter_reg;
    hrdata_next    = hrdata_reg;
    if (req_reg.valid && req_reg.write)
    begin
      unique case (req_reg.addr)
        `ATS_OFF_CFG:
        begin
          complex_next = hwdata_in[`ATS_CFG_COMPLEX];
          expr_next    = ats_pkg::ats_expr_type'(hwdata_in[`ATS_CFG_EXPR_HI:`ATS_CFG_EXPR_LO]);
          out_sel_next = hwdata_in[`ATS_CFG_OUT_B:`ATS_CFG_OUT_A];
          arm_src_next = ats_pkg::ats_arm_type'(hwdata_in[`ATS_CFG_ARM_HI:`ATS_CFG_ARM_LO]);
        end
        `ATS_OFF_PATTERN:  pattern_next = hwdata_in;
        `ATS_OFF_MASK:     mask_next = hwdata_in;
        `ATS_OFF_COUNT:    count_next = (hwdata_in[15:0] == 16'h0000) ? `ATS_COUNT_MIN : hwdata_in[15:0]; // [RULE1]
        `ATS_OFF_STORE:    store_next = hwdata_in;
        `ATS_OFF_IRQ_MASK: irq_mask_next = hwdata_in[1:0];
        `ATS_OFF_SEQ:
        begin
          term_cfg_next[0].sec_sel = ats_pkg::ats_expr_type'(hwdata_in[`ATS_SEQ_SEC_HI:`ATS_SEQ_SEC_LO]);
          restart_next = ats_pkg::ats_expr_type'(hwdata_in[`ATS_SEQ_RST_HI:`ATS_SEQ_RST_LO]);
        end
        default:           hrdata_next = hrdata_reg;
      endcase
    end
    if (cmd_setup)
    begin
      // the storage qualifier is deliberately left alone here [RULE4]
      term_cfg_next[0].pri_sel = expr_next;
      term_cfg_next[0].count   = count_next; // [RULE1]
      if (complex_next)
      begin
        trig_enter_next          = 1'b1; // [RULE3]
        term_cfg_next[0].pri_dest = 1'b1; // [RULE3]
        term_cfg_next[1].sec_sel = ats_pkg::ATS_EXPR_NEVER; // [RULE3]
      end
      else
      begin
        trig_enter_next = 1'b0; // [RULE2]
        restart_next    = ats_pkg::ATS_EXPR_NEVER; // [RULE2]
      end
    end
    if (cmd_init)
    begin
      complex_next    = 1'b0;
      expr_next       = ats_pkg::ATS_EXPR_ANY;
      out_sel_next    = 2'b00; // [RULE6]
      arm_src_next    = ats_pkg::ATS_ARM_ALWAYS;
      count_next      = `ATS_COUNT_RESET;
      restart_next    = ats_pkg::ATS_EXPR_NEVER;
      trig_enter_next = 1'b0;
      for (int i = 0; i < TERMS; i++)
      begin
        term_cfg_next[i] = '{pri_sel: ats_pkg::ATS_EXPR_ANY, sec_sel: ats_pkg::ATS_EXPR_NEVER,
                             count: `ATS_COUNT_RESET, pri_dest: 1'b1};
      end
    end
    if (addr_take && !hwrite_in)
    begin
      unique case (haddr_in[7:0])
        `ATS_OFF_CFG:      hrdata_next = {25'h0000000, arm_src_reg, out_sel_reg, expr_reg, complex_reg};
        `ATS_OFF_PATTERN:  hrdata_next = pattern_reg;
        `ATS_OFF_MASK:     hrdata_next = mask_reg;
        `ATS_OFF_COUNT:    hrdata_next = {16'h0000, count_reg};
        `ATS_OFF_STORE:    hrdata_next = store_reg;
        `ATS_OFF_STATUS:   hrdata_next = {26'h0000000, run_reg, term_reg, armed_reg, trig_reg, complex_reg};
        `ATS_OFF_IRQ_STAT: hrdata_next = {30'h00000000, irq_stat_reg};
        `ATS_OFF_IRQ_MASK: hrdata_next = {30'h00000000, irq_mask_reg};
        `ATS_OFF_SEQ:      hrdata_next = {occ_count[0], 6'h00, trig_enter_reg, restart_reg,
                                          term_cfg_reg[0].pri_dest, term_cfg_reg[0].sec_sel,
                                          term_cfg_reg[0].pri_sel, 2'b00};
        default:           hrdata_next = 32'h00000000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequencer
  assign pat_match = ((bus_state_in ^ pattern_reg) & mask_reg) == 32'h00000000;
  assign arm_seen  = (arm_src_reg == ats_pkg::ATS_ARM_LINE_A) ? cross_trigger_line_a_in :
                     (arm_src_reg == ats_pkg::ATS_ARM_LINE_B) ? cross_trigger_line_b_in : 1'b1;
  assign active    = (run_reg == ats_pkg::ATS_RUN) && !trig_reg && bus_state_valid_in;
  assign sec_hit   = qual(complex_reg ? term_cfg_reg[term_reg].sec_sel : restart_reg, pat_match, armed_reg);

  genvar g;
  generate
    for (g = 0; g < TERMS; g++)
    begin : g_term
      assign pri_hit[g] = active && (term_reg == 1'(g)) && qual(term_cfg_reg[g].pri_sel, pat_match, armed_reg);
      ats_occ_counter u_occ
      (
        .clk_in    (clk_in),
        .rst_in    (rst_in),
        .reload_in (reload[g]),
        .hit_in    (pri_hit[g]),
        .limit_in  (term_cfg_reg[g].count),
        .done_out  (done[g]),
        .count_out (occ_count[g])
      ); // [RULE11]
    end
  endgenerate

  assign trig_event = trig_next && !trig_reg;
  assign halt_event = (run_next != ats_pkg::ATS_RUN) && (run_reg == ats_pkg::ATS_RUN);

  always_comb
  begin
    run_next   = run_reg;
    term_next  = term_reg;
    armed_next = armed_reg;
    trig_next  = trig_reg;
    reload     = '0;
    if (run_reg == ats_pkg::ATS_RUN && arm_seen)
    begin
      armed_next = 1'b1; // [RULE5]
    end
    if (active)
    begin
      if (done[term_reg])
      begin
        // a completed primary beats a secondary in the same state [RULE8]
        if (!complex_reg)
        begin
          trig_next = 1'b1; // [RULE1] [RULE2]
        end
        else
        begin
          term_next = term_cfg_reg[term_reg].pri_dest;
          reload[term_cfg_reg[term_reg].pri_dest] = 1'b1; // [RULE11]
          if (trig_enter_reg && term_cfg_reg[term_reg].pri_dest)
          begin
            trig_next = 1'b1; // [RULE3]
          end
        end
      end
      else if (sec_hit)
      begin
        term_next = 1'b0;
        reload    = '1; // [RULE9] [RULE11]
      end
    end
    if (cmd_start)
    begin
      run_next   = ats_pkg::ATS_RUN;
      term_next  = 1'b0;
      armed_next = 1'b0;
      trig_next  = 1'b0;
      reload     = '1; // [RULE11]
    end
    if (cmd_halt || cmd_init)
    begin
      run_next = ats_pkg::ATS_DONE; // [RULE10]
    end
  end

  // set beats read clear
  always_comb
  begin
    irq_stat_next = rd_stat ? 2'b00 : irq_stat_reg;
    if (trig_event)
      irq_stat_next[`ATS_IRQ_TRIG] = 1'b1;
    if (halt_event)
      irq_stat_next[`ATS_IRQ_HALT] = 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  always_comb
  begin
    trigger_found_out        = trig_reg;
    cross_trigger_line_a_out = 1'b0;
    cross_trigger_line_b_out = 1'b0;
    if (trig_reg && run_reg == ats_pkg::ATS_RUN) // [RULE10]
    begin
      cross_trigger_line_a_out = out_sel_reg[0] && (arm_src_reg != ats_pkg::ATS_ARM_LINE_A); // [RULE6] [RULE7]
      cross_trigger_line_b_out = out_sel_reg[1] && (arm_src_reg != ats_pkg::ATS_ARM_LINE_B); // [RULE6] [RULE7]
    end
  end

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      req_reg        <= '0;
      complex_reg    <= 1'b0;
      expr_reg       <= ats_pkg::ATS_EXPR_ANY;
      out_sel_reg    <= 2'b00;
      arm_src_reg    <= ats_pkg::ATS_ARM_ALWAYS;
      pattern_reg    <= `ATS_PATTERN_RST;
      mask_reg       <= `ATS_MASK_RST;
      count_reg      <= `ATS_COUNT_RESET;
      store_reg      <= `ATS_STORE_RST;
      irq_stat_reg   <= 2'b00;
      irq_mask_reg   <= 2'b00;
      hrdata_reg     <= 32'h00000000;
      restart_reg    <= ats_pkg::ATS_EXPR_NEVER;
      trig_enter_reg <= 1'b0;
      for (int i = 0; i < TERMS; i++)
      begin
        term_cfg_reg[i] <= '{pri_sel: ats_pkg::ATS_EXPR_ANY, sec_sel: ats_pkg::ATS_EXPR_NEVER,
                             count: `ATS_COUNT_RESET, pri_dest: 1'b1};
      end
      run_reg        <= ats_pkg::ATS_IDLE;
      term_reg       <= 1'b0;
      armed_reg      <= 1'b0;
      trig_reg       <= 1'b0;
    end
    else
    begin
      req_reg        <= req_next;
      complex_reg    <= complex_next;
      expr_reg       <= expr_next;
      out_sel_reg    <= out_sel_next;
      arm_src_reg    <= arm_src_next;
      pattern_reg    <= pattern_next;
      mask_reg       <= mask_next;
      count_reg      <= count_next;
      store_reg      <= store_next;
      irq_stat_reg   <= irq_stat_next;
      irq_mask_reg   <= irq_mask_next;
      hrdata_reg     <= hrdata_next;
      restart_reg    <= restart_next;
      trig_enter_reg <= trig_enter_next;
      term_cfg_reg   <= term_cfg_next;
      run_reg        <= run_next;
      term_reg       <= term_next;
      armed_reg      <= armed_next;
      trig_reg       <= trig_next;
    end
  end
endmodule

// *** verification/ats_bus_model.sv ***
`timescale 1ns/1ps
module ats_bus_model
(
  input  wire logic  clk_in,
  output logic [31:0] bus_state_out,
  output logic        valid_out,
  output logic        arm_a_out,
  output logic        arm_b_out
);
  initial
  begin
    bus_state_out = 32'h0000_0000;
    valid_out = 1'b0;
    arm_a_out = 1'b0;
    arm_b_out = 1'b0;
  end

  // n states, one per cycle; bus shows junk once released
  task automatic send(input int n, input logic [31:0] st);
    repeat (n)
    begin
      @(posedge clk_in);
      valid_out <= 1'b1;
      bus_state_out <= st;
    end
    @(posedge clk_in);
    valid_out <= 1'b0;
    bus_state_out <= ~st;
  endtask

  task automatic arm(input logic a, input logic b);
    @(posedge clk_in);
    arm_a_out <= a;
    arm_b_out <= b;
  endtask
endmodule

// *** verification/ats_trigger_setup_assertions.sv ***
`timescale 1ns/1ps
module ats_trigger_setup_assertions
(
  input wire logic        clk_in,
  input wire logic        rst_in,
  input wire logic        hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0]  htrans_in,
  input wire logic        hwrite_in,
  input wire logic [31:0] hwdata_in,
  input wire logic        hready_in,
  input wire logic        bus_state_valid_in,
  input wire logic        cross_trigger_line_a_out,
  input wire logic        cross_trigger_line_b_out,
  input wire logic        trigger_found_out,
  input wire logic        irq_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);

  logic addr_ph;
  logic acc_ph;
  logic cmd_reg;
  logic cmd_next;

  always_comb
  begin
    addr_ph = hsel_in & hready_in & htrans_in[1];
    acc_ph = addr_ph & (haddr_in[7:0] == 8'h1c || haddr_in[7:0] == 8'h20 || haddr_in[7:0] == 8'h00);
    cmd_next = addr_ph & hwrite_in & (haddr_in[7:0] == 8'h00);
  end

  always_ff @(posedge clk_in or posedge rst_in)
    if (rst_in)
      cmd_reg <= 1'b0;
    else
      cmd_reg <= cmd_next;

  ////////////////////////////////////////////////////////////////
  sequence s_cmd_bit(int b);
    cmd_reg && hwdata_in[b];
  endsequence

  property p_line_a_needs_trig;
    cross_trigger_line_a_out |-> trigger_found_out;
  endproperty
  property p_line_b_needs_trig;
    cross_trigger_line_b_out |-> trigger_found_out;
  endproperty
  property p_trig_after_state;
    $rose(trigger_found_out) |-> $past(bus_state_valid_in);
  endproperty
  property p_halt_drops_lines;
    s_cmd_bit(1) |-> ##[1:2] !(cross_trigger_line_a_out || cross_trigger_line_b_out);
  endproperty
  property p_init_drops_lines;
    s_cmd_bit(3) |-> ##[1:2] !(cross_trigger_line_a_out || cross_trigger_line_b_out);
  endproperty
  property p_start_clears;
    s_cmd_bit(0) |-> ##1 !trigger_found_out;
  endproperty
  property p_found_holds;
    $fell(trigger_found_out) |-> $past(cmd_reg && (hwdata_in[0] || hwdata_in[3]));
  endproperty
  property p_irq_fall_on_access;
    $fell(irq_out) |-> $past(acc_ph, 1) || $past(acc_ph, 2) || $past(acc_ph, 3);
  endproperty

  a_line_a_needs_trig: assert property (p_line_a_needs_trig) else $error("line a without trigger");
  a_line_b_needs_trig: assert property (p_line_b_needs_trig) else $error("line b without trigger");
  a_trig_after_state: assert property (p_trig_after_state) else $error("trigger without state");
  a_halt_drops_lines: assert property (p_halt_drops_lines) else $error("lines kept after halt");
  a_init_drops_lines: assert property (p_init_drops_lines) else $error("lines kept after init");
  a_start_clears: assert property (p_start_clears) else $error("trigger kept after start");
  a_found_holds: assert property (p_found_holds) else $error("trigger dropped alone");
  a_irq_fall_on_access: assert property (p_irq_fall_on_access) else $error("irq dropped alone");
endmodule

// *** verification/ats_trigger_setup_bench.sv ***
`timescale 1ns/1ps
module ats_trigger_setup_bench;
  logic        clk_in;
  logic        rst_in;
  logic        hsel_in;
  logic [31:0] haddr_in;
  logic [1:0]  htrans_in;
  logic        hwrite_in;
  logic [31:0] hwdata_in;
  logic        hreadyout_out;
  logic        hresp_out;
  logic [31:0] hrdata_out;
  logic [31:0] bus_state_in;
  logic        bus_state_valid_in;
  logic        line_a_in;
  logic        line_b_in;
  logic        line_a_out;
  logic        line_b_out;
  logic        found;
  logic        irq;
  logic [31:0] rd;
  int          n_errors;
  int          comparisons;

  ats_trigger_setup i_dut (.clk_in(clk_in), .rst_in(rst_in), .hsel_in(hsel_in), .haddr_in(haddr_in),
    .htrans_in(htrans_in), .hwrite_in(hwrite_in), .hsize_in(3'h2), .hwdata_in(hwdata_in),
    .hready_in(hreadyout_out), .hreadyout_out(hreadyout_out), .hresp_out(hresp_out), .hrdata_out(hrdata_out),
    .bus_state_in(bus_state_in), .bus_state_valid_in(bus_state_valid_in), .cross_trigger_line_a_in(line_a_in),
    .cross_trigger_line_b_in(line_b_in), .cross_trigger_line_a_out(line_a_out),
    .cross_trigger_line_b_out(line_b_out), .trigger_found_out(found), .irq_out(irq));

  ats_bus_model i_model (.clk_in(clk_in), .bus_state_out(bus_state_in), .valid_out(bus_state_valid_in),
    .arm_a_out(line_a_in), .arm_b_out(line_b_in));

  initial
  begin
    clk_in = 1'b0;
    forever #20 clk_in = ~clk_in;
  end

  ////////////////////////////////////////////////////////////////
  task automatic summarize;
    $display("checks %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp)
    begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic rdy;
    int i;
    i = 0;
    do
    begin
      @(posedge clk_in);
      i++;
    end
    while (hreadyout_out !== 1'b1 && i < 100);
    if (hreadyout_out !== 1'b1)
    begin
      n_errors++;
      summarize();
    end
  endtask

  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge clk_in);
    hsel_in <= 1'b1;
    htrans_in <= 2'h2;
    haddr_in <= {24'h00_0000, a};
    hwrite_in <= w;
    rdy();
    hsel_in <= 1'b0;
    htrans_in <= 2'h0;
    hwdata_in <= d;
    rdy();
    rd = hrdata_out;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(a, 1'b1, d);
  endtask

  task automatic rdc(input string what, input logic [7:0] a, input logic [31:0] exp);
    xfer(a, 1'b0, 32'h0000_0000);
    chk(what, exp, rd);
  endtask

  task automatic settle;
    repeat (3) @(posedge clk_in);
  endtask

  ////////////////////////////////////////////////////////////////
  task automatic t_reset;
    rdc("cfg", 8'h04, 32'h0000_0000);
    rdc("count", 8'h10, 32'h0000_0001);
    wr(8'h30, 32'hffff_ffff);
    rdc("unmapped", 8'h30, 32'h0000_0000);
    chk("lines", 32'h0000_0000, {30'h0, line_a_out, line_b_out});
    chk("hresp", 32'h0000_0000, {31'h0, hresp_out});
    wr(8'h10, 32'h0000_0000);
    rdc("count_zero", 8'h10, 32'h0000_0001);
    wr(8'h10, 32'h0000_ffff);
    rdc("count_max", 8'h10, 32'h0000_ffff);
    $display("test reset done");
  endtask

  task automatic t_easy;
    wr(8'h14, 32'h0000_a5a5);
    wr(8'h08, 32'h0000_1234);
    wr(8'h0c, 32'hffff_ffff);
    wr(8'h10, 32'h0000_0003);
    wr(8'h20, 32'h0000_0000);
    wr(8'h04, 32'h0000_000c);
    wr(8'h00, 32'h0000_0004);
    xfer(8'h24, 1'b0, 32'h0000_0000);
    chk("seq_easy", 32'h0000_0088, rd & 32'h0000_038c);
    wr(8'h00, 32'h0000_0001);
    i_model.send(2, 32'h0000_1234);
    i_model.send(3, 32'h0000_9999);
    settle();
    chk("found_early", 32'h0, {31'h0, found});
    i_model.send(1, 32'h0000_1234);
    settle();
    chk("found", 32'h1, {31'h0, found});
    chk("lines_a", 32'h2, {30'h0, line_a_out, line_b_out});
    chk("irq_masked", 32'h0, {31'h0, irq});
    wr(8'h20, 32'h0000_0001);
    @(posedge clk_in);
    chk("irq", 32'h1, {31'h0, irq});
    rdc("store", 8'h14, 32'h0000_a5a5);
    wr(8'h00, 32'h0000_0002);
    settle();
    chk("lines_halt", 32'h0, {30'h0, line_a_out, line_b_out});
    rdc("irq_stat", 8'h1c, 32'h0000_0003);
    rdc("irq_clear", 8'h1c, 32'h0000_0000);
    chk("irq_off", 32'h0, {31'h0, irq});
    $display("test easy done");
  endtask

  task automatic t_complex;
    wr(8'h04, 32'h0000_0019);
    wr(8'h10, 32'h0000_0002);
    wr(8'h00, 32'h0000_0004);
    xfer(8'h24, 1'b0, 32'h0000_0000);
    chk("seq_cplx", 32'h0000_0240, rd & 32'h0000_0240);
    wr(8'h00, 32'h0000_0001);
    i_model.send(1, 32'h0000_0042);
    settle();
    chk("found_early", 32'h0, {31'h0, found});
    i_model.send(1, 32'h0000_0043);
    settle();
    chk("found", 32'h1, {31'h0, found});
    chk("lines_ab", 32'h3, {30'h0, line_a_out, line_b_out});
    xfer(8'h18, 1'b0, 32'h0000_0000);
    chk("status", 32'h0000_001b, rd & 32'h0000_003b);
    wr(8'h00, 32'h0000_0002);
    $display("test complex done");
  endtask

  task automatic t_arm;
    wr(8'h04, 32'h0000_003e);
    wr(8'h10, 32'h0000_0001);
    wr(8'h00, 32'h0000_0004);
    wr(8'h00, 32'h0000_0001);
    i_model.send(3, 32'h0000_0000);
    settle();
    chk("found_unarmed", 32'h0, {31'h0, found});
    i_model.arm(1'b1, 1'b0);
    settle();
    i_model.send(1, 32'h0000_0000);
    settle();
    chk("found_armed", 32'h1, {31'h0, found});
    chk("lines_arm", 32'h1, {30'h0, line_a_out, line_b_out});
    i_model.arm(1'b0, 1'b0);
    wr(8'h00, 32'h0000_0008);
    rdc("cfg_init", 8'h04, 32'h0000_0000);
    chk("lines_init", 32'h0, {30'h0, line_a_out, line_b_out});
    $display("test arm done");
  endtask

  task automatic t_branch;
    wr(8'h04, 32'h0000_0004);
    wr(8'h10, 32'h0000_0002);
    wr(8'h00, 32'h0000_0004);
    wr(8'h24, 32'h0000_0000);
    wr(8'h00, 32'h0000_0001);
    i_model.send(3, 32'h0000_1234);
    settle();
    chk("found_restart", 32'h0, {31'h0, found});
    xfer(8'h24, 1'b0, 32'h0000_0000);
    chk("occ_cleared", 32'h0, rd & 32'hffff_0000);
    wr(8'h10, 32'h0000_0001);
    wr(8'h00, 32'h0000_0004);
    wr(8'h24, 32'h0000_0000);
    wr(8'h00, 32'h0000_0001);
    i_model.send(1, 32'h0000_1234);
    settle();
    chk("found_same_state", 32'h1, {31'h0, found});
    wr(8'h00, 32'h0000_0002);
    $display("test branch done");
  endtask

  initial
  begin
    rst_in = 1'b1;
    hsel_in = 1'b0;
    haddr_in = 32'h0000_0000;
    htrans_in = 2'h0;
    hwrite_in = 1'b0;
    hwdata_in = 32'h0000_0000;
    n_errors = 0;
    comparisons = 0;
    repeat (2) @(posedge clk_in);
    rst_in <= 1'b0;
    t_reset();
    t_easy();
    t_complex();
    t_arm();
    t_branch();
    summarize();
  end

  initial
  begin
    repeat (20000) @(posedge clk_in);
    n_errors++;
    $display("Error watchdog expected finish seen hang");
    summarize();
  end
endmodule

bind ats_trigger_setup ats_trigger_setup_assertions i_chk (.clk_in(clk_in), .rst_in(rst_in), .hsel_in(hsel_in),
  .haddr_in(haddr_in), .htrans_in(htrans_in), .hwrite_in(hwrite_in), .hwdata_in(hwdata_in),
  .hready_in(hready_in), .bus_state_valid_in(bus_state_valid_in),
  .cross_trigger_line_a_out(cross_trigger_line_a_out), .cross_trigger_line_b_out(cross_trigger_line_b_out),
  .trigger_found_out(trigger_found_out), .irq_out(irq_out));
